// file: core/sse_status_flags.sv
// Status, error flags and interrupt requests of the serial interface, APB slave
// Notes on behaviour
// - Buffer hand-off sets tx empty; reset sets it
// - Tx empty clears: status read, then data write
// - Tx complete when empty and idle; queue clears
// - Reset sets tx complete
// - Rx full set on load, cleared by sequence
// - Idle sets on ones run; sequence clears it
// - Idle needs a character after enable or clear
// - Overrun: new character dropped, buffer kept
// - Overrun clears only if status read saw it
// - Noise flag set on noise, sequence clears
// - Framing flag set on zero stop bit
// - Parity flag set on parity failure
// - Error enables gate shared error interrupt
// - Tx and rx enables gate their interrupts
// - Break sets break, framing, full; clears ninth in nine-bit mode
// - Break clears by sequence; rearms after ones
// - In-progress set at first sample, cleared
// - Ninth bit captured with the data byte
module sse_status_flags (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Transmit shifter side
	input wire logic tx_load_pulse,
	input wire logic tx_busy,
	input wire logic tx_queue_pulse,
	output logic [7:0] tx_data,
	output logic tx_ninth_bit,
	output logic tx_data_write,
	// Receive shifter side
	input wire logic nine_bit_mode,
	input wire logic rx_char_done,
	input wire logic [8:0] rx_char,
	input wire logic rx_noise_event,
	input wire logic rx_parity_event,
	input wire logic rx_stop_zero_event,
	input wire logic rx_break_event,
	input wire logic rx_line_ones_event,
	input wire logic rx_idle_event,
	input wire logic rx_start_sample_zero,
	input wire logic rx_false_start,
	// Interrupt requests and control out
	output logic tx_irq,
	output logic rx_irq,
	output logic err_irq,
	output logic tx_dma_req,
	output logic rx_enable
);
	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	logic pready_reg; // Completion strobe, one wait state
	logic [31:0] prdata_reg; // Read data captured in the wait cycle
	logic pslverr_reg; // Unmapped address answer
	wire access_wait = psel & penable & ~pready_reg;
	wire access_done = psel & penable & pready_reg;
	wire hit_c2 = paddr == sse_pkg::OFS_CONTROL_TWO;
	wire hit_c3 = paddr == sse_pkg::OFS_CONTROL_THREE;
	wire hit_s1 = paddr == sse_pkg::OFS_STATUS_ONE;
	wire hit_s2 = paddr == sse_pkg::OFS_STATUS_TWO;
	wire hit_dr = paddr == sse_pkg::OFS_DATA_BUFFER;
	wire hit_any = hit_c2 | hit_c3 | hit_s1 | hit_s2 | hit_dr;
	wire wr_c2 = access_done & pwrite & hit_c2;
	wire wr_c3 = access_done & pwrite & hit_c3;
	wire wr_dr = access_done & pwrite & hit_dr;
	wire rd_s1 = access_done & ~pwrite & hit_s1;
	wire rd_s2 = access_done & ~pwrite & hit_s2;
	wire rd_dr = access_done & ~pwrite & hit_dr;
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [7:0] control_two_reg; // Interrupt enables and receiver enable
	logic [7:0] control_three_reg; // Ninth bits, steering, error enables
	logic [7:0] rx_buffer_reg; // Received byte
	logic rx_ninth_bit_reg; // Received ninth bit
	logic [7:0] tx_data_reg; // Byte written for transmission
	logic tx_write_reg; // One-cycle write strobe to the shifter
	logic tx_empty_flag_reg;
	logic tx_complete_flag_reg;
	logic rx_full_flag_reg;
	logic idle_flag_reg;
	logic overrun_flag_reg;
	logic rx_noise_flag_reg;
	logic rx_framing_error_flag_reg;
	logic rx_parity_error_flag_reg;
	logic break_detect_flag_reg;
	logic rx_in_progress_flag_reg;
	logic [7:0] s1_arm_reg; // Flags seen set by the last status one read
	logic break_arm_reg; // Break seen set by the last status two read
	logic break_ready_reg; // Ones seen since the last break
	logic idle_allowed_reg; // A character has filled the buffer since gating
	logic rx_enable_d_reg; // Receiver enable, delayed for edge detect
	logic tx_irq_reg;
	logic rx_irq_reg;
	logic err_irq_reg;
	logic tx_dma_reg;
	// ------------------------------------------------------------
	// Read multiplexer
	// ------------------------------------------------------------
	wire [7:0] status_one = {tx_empty_flag_reg, tx_complete_flag_reg, rx_full_flag_reg,
		idle_flag_reg, overrun_flag_reg, rx_noise_flag_reg, rx_framing_error_flag_reg,
		rx_parity_error_flag_reg};
	wire [7:0] status_two = {6'h00, break_detect_flag_reg, rx_in_progress_flag_reg};
	wire [7:0] control_three_view = {rx_ninth_bit_reg, control_three_reg[6:0]};
	wire [7:0] read_byte = hit_c2 ? control_two_reg :
		hit_c3 ? control_three_view :
		hit_s1 ? status_one :
		hit_s2 ? status_two :
		hit_dr ? rx_buffer_reg : 8'h00;
	// ------------------------------------------------------------
	// Flag clearing terms: data access after an armed status read
	// ------------------------------------------------------------
	wire clr_tx_empty = wr_dr & s1_arm_reg[sse_pkg::S1_TX_EMPTY];
	wire clr_rx_full = rd_dr & s1_arm_reg[sse_pkg::S1_RX_FULL];
	wire clr_idle = rd_dr & s1_arm_reg[sse_pkg::S1_IDLE];
	wire clr_overrun = rd_dr & s1_arm_reg[sse_pkg::S1_OVERRUN];
	wire clr_noise = rd_dr & s1_arm_reg[sse_pkg::S1_NOISE];
	wire clr_framing = rd_dr & s1_arm_reg[sse_pkg::S1_FRAMING];
	wire clr_parity = rd_dr & s1_arm_reg[sse_pkg::S1_PARITY];
	wire clr_break = rd_dr & break_arm_reg;
	// ------------------------------------------------------------
	// Receive events
	// ------------------------------------------------------------
	wire buffer_busy = rx_full_flag_reg & ~clr_rx_full;
	wire char_accept = rx_char_done & ~buffer_busy;
	wire char_overrun = rx_char_done & buffer_busy;
	wire break_take = rx_break_event & break_ready_reg & ~buffer_busy;
	wire buffer_load = char_accept | break_take;
	wire idle_set = rx_idle_event & idle_allowed_reg;
	wire rx_enable_rise = control_two_reg[sse_pkg::C2_RX_ENABLE] & ~rx_enable_d_reg;
	wire ninth_in = nine_bit_mode ? rx_char[sse_pkg::CHAR_BIT_EIGHT] :
		rx_char[sse_pkg::CHAR_BIT_SEVEN];
	// ------------------------------------------------------------
	// Interrupt terms
	// ------------------------------------------------------------
	wire tx_empty_req = tx_empty_flag_reg & control_two_reg[sse_pkg::C2_TX_EMPTY_IE];
	wire tx_empty_cpu = tx_empty_req & ~control_three_reg[sse_pkg::C3_TX_DMA];
	wire tx_irq_next = tx_empty_cpu |
		(tx_complete_flag_reg & control_two_reg[sse_pkg::C2_TX_COMPLETE_IE]);
	wire rx_irq_next = (rx_full_flag_reg & control_two_reg[sse_pkg::C2_RX_FULL_IE]) |
		(idle_flag_reg & control_two_reg[sse_pkg::C2_IDLE_IE]);
	wire err_irq_next = (overrun_flag_reg & control_three_reg[sse_pkg::C3_OVERRUN_IE]) |
		(rx_noise_flag_reg & control_three_reg[sse_pkg::C3_NOISE_IE]) |
		(rx_framing_error_flag_reg & control_three_reg[sse_pkg::C3_FRAMING_IE]) |
		(rx_parity_error_flag_reg & control_three_reg[sse_pkg::C3_PARITY_IE]);
	// ------------------------------------------------------------
	// APB handshake and read capture
	// ------------------------------------------------------------
	// Wait cycle captures data, next edge completes the transfer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg <= access_wait;
			if (access_wait) begin
				prdata_reg <= {24'h00_0000, pwrite ? 8'h00 : read_byte};
				pslverr_reg <= ~hit_any;
			end else begin
				pslverr_reg <= 1'b0;
			end
		end
	end
	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	// Software writes; reset clears all enables
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			control_two_reg <= sse_pkg::C2_RESET;
			control_three_reg <= sse_pkg::C3_RESET;
			rx_enable_d_reg <= 1'b0;
		end else begin
			rx_enable_d_reg <= control_two_reg[sse_pkg::C2_RX_ENABLE];
			if (wr_c2) begin
				control_two_reg <= pwdata[7:0] & sse_pkg::C2_WRITE_MASK;
			end
			if (wr_c3) begin
				control_three_reg <= pwdata[7:0] & sse_pkg::C3_WRITE_MASK;
			end
		end
	end
	// ------------------------------------------------------------
	// Data paths
	// ------------------------------------------------------------
	// Transmit byte latch and receive buffer with ninth bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_data_reg <= 8'h00;
			tx_write_reg <= 1'b0;
			rx_buffer_reg <= 8'h00;
			rx_ninth_bit_reg <= 1'b0;
		end else begin
			tx_write_reg <= wr_dr;
			if (wr_dr) begin
				tx_data_reg <= pwdata[7:0];
			end
			if (buffer_load) begin
				// Overrun leaves the buffered byte untouched
				rx_buffer_reg <= rx_char[7:0];
				if (break_take && nine_bit_mode) begin
					rx_ninth_bit_reg <= 1'b0;
				end else begin
					rx_ninth_bit_reg <= ninth_in;
				end
			end
		end
	end
	// ------------------------------------------------------------
	// Clear-sequence records
	// ------------------------------------------------------------
	// A status read records the flags it returned; a data read ends both records, a data write only the status one record
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_arm_reg <= 8'h00;
			break_arm_reg <= 1'b0;
		end else begin
			if (rd_s1) begin
				s1_arm_reg <= prdata_reg[7:0];
			end else if (rd_dr || wr_dr) begin
				s1_arm_reg <= 8'h00;
			end
			if (rd_s2) begin
				break_arm_reg <= prdata_reg[sse_pkg::S2_BREAK];
			end else if (rd_dr) begin
				break_arm_reg <= 1'b0;
			end
		end
	end
	// ------------------------------------------------------------
	// Transmit flags
	// ------------------------------------------------------------
	// Set wins over clear on tx empty
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_empty_flag_reg <= 1'b1;
			tx_complete_flag_reg <= 1'b1;
		end else begin
			if (tx_load_pulse) begin
				tx_empty_flag_reg <= 1'b1;
			end else if (clr_tx_empty) begin
				tx_empty_flag_reg <= 1'b0;
			end
			// Complete only while empty, idle and nothing queued
			tx_complete_flag_reg <= tx_empty_flag_reg & ~tx_busy & ~tx_queue_pulse;
		end
	end
	// ------------------------------------------------------------
	// Receive flags
	// ------------------------------------------------------------
	// Each flag: event sets, armed data read clears, set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_full_flag_reg <= 1'b0;
			idle_flag_reg <= 1'b0;
			overrun_flag_reg <= 1'b0;
			rx_noise_flag_reg <= 1'b0;
			rx_framing_error_flag_reg <= 1'b0;
			rx_parity_error_flag_reg <= 1'b0;
		end else begin
			if (buffer_load) begin
				rx_full_flag_reg <= 1'b1;
			end else if (clr_rx_full) begin
				rx_full_flag_reg <= 1'b0;
			end
			if (idle_set) begin
				idle_flag_reg <= 1'b1;
			end else if (clr_idle) begin
				idle_flag_reg <= 1'b0;
			end
			if (char_overrun) begin
				overrun_flag_reg <= 1'b1;
			end else if (clr_overrun) begin
				overrun_flag_reg <= 1'b0;
			end
			if (rx_noise_event) begin
				rx_noise_flag_reg <= 1'b1;
			end else if (clr_noise) begin
				rx_noise_flag_reg <= 1'b0;
			end
			if (rx_stop_zero_event || break_take) begin
				rx_framing_error_flag_reg <= 1'b1;
			end else if (clr_framing) begin
				rx_framing_error_flag_reg <= 1'b0;
			end
			if (rx_parity_event) begin
				rx_parity_error_flag_reg <= 1'b1;
			end else if (clr_parity) begin
				rx_parity_error_flag_reg <= 1'b0;
			end
		end
	end
	// ------------------------------------------------------------
	// Break, in-progress and idle gating
	// ------------------------------------------------------------
	// Break rearms on ones; idle gate opens on a character
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			break_detect_flag_reg <= 1'b0;
			break_ready_reg <= 1'b1;
			rx_in_progress_flag_reg <= 1'b0;
			idle_allowed_reg <= 1'b0;
		end else begin
			if (break_take) begin
				break_detect_flag_reg <= 1'b1;
			end else if (clr_break) begin
				break_detect_flag_reg <= 1'b0;
			end
			if (break_take) begin
				break_ready_reg <= 1'b0;
			end else if (rx_line_ones_event) begin
				break_ready_reg <= 1'b1;
			end
			if (rx_start_sample_zero) begin
				rx_in_progress_flag_reg <= 1'b1;
			end else if (rx_false_start || rx_idle_event) begin
				rx_in_progress_flag_reg <= 1'b0;
			end
			if (buffer_load) begin
				idle_allowed_reg <= 1'b1;
			end else if (rx_enable_rise || idle_set || clr_idle) begin
				idle_allowed_reg <= 1'b0;
			end
		end
	end
	// ------------------------------------------------------------
	// Interrupt request outputs
	// ------------------------------------------------------------
	// Registered so every request leaves from a flip-flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_irq_reg <= 1'b0;
			rx_irq_reg <= 1'b0;
			err_irq_reg <= 1'b0;
			tx_dma_reg <= 1'b0;
		end else begin
			tx_irq_reg <= tx_irq_next;
			rx_irq_reg <= rx_irq_next;
			err_irq_reg <= err_irq_next;
			tx_dma_reg <= tx_empty_req & control_three_reg[sse_pkg::C3_TX_DMA];
		end
	end
	// ------------------------------------------------------------
	// Output wiring
	// ------------------------------------------------------------
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign tx_data = tx_data_reg;
	assign tx_ninth_bit = control_three_reg[sse_pkg::C3_TX_NINTH];
	assign tx_data_write = tx_write_reg;
	assign tx_irq = tx_irq_reg;
	assign rx_irq = rx_irq_reg;
	assign err_irq = err_irq_reg;
	assign tx_dma_req = tx_dma_reg;
	assign rx_enable = control_two_reg[sse_pkg::C2_RX_ENABLE];
endmodule

// file: core/sse_pkg.sv
// Package: register map, field positions and reset values of the serial status block
package sse_pkg;
	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CONTROL_TWO = 8'h00;
	localparam logic [7:0] OFS_CONTROL_THREE = 8'h04;
	localparam logic [7:0] OFS_STATUS_ONE = 8'h08;
	localparam logic [7:0] OFS_STATUS_TWO = 8'h0C;
	localparam logic [7:0] OFS_DATA_BUFFER = 8'h10;
	// ------------------------------------------------------------
	// Control two fields
	// ------------------------------------------------------------
	localparam int C2_TX_EMPTY_IE = 7;
	localparam int C2_TX_COMPLETE_IE = 6;
	localparam int C2_RX_FULL_IE = 5;
	localparam int C2_IDLE_IE = 4;
	localparam int C2_RX_ENABLE = 2;
	localparam logic [7:0] C2_WRITE_MASK = 8'hF4;
	localparam logic [7:0] C2_RESET = 8'h00;
	// ------------------------------------------------------------
	// Control three fields
	// ------------------------------------------------------------
	localparam int C3_RX_NINTH = 7;
	localparam int C3_TX_NINTH = 6;
	localparam int C3_RX_DMA = 5;
	localparam int C3_TX_DMA = 4;
	localparam int C3_OVERRUN_IE = 3;
	localparam int C3_NOISE_IE = 2;
	localparam int C3_FRAMING_IE = 1;
	localparam int C3_PARITY_IE = 0;
	localparam logic [7:0] C3_WRITE_MASK = 8'h7F;
	localparam logic [7:0] C3_RESET = 8'h00;
	// ------------------------------------------------------------
	// Status one fields
	// ------------------------------------------------------------
	localparam int S1_TX_EMPTY = 7;
	localparam int S1_TX_COMPLETE = 6;
	localparam int S1_RX_FULL = 5;
	localparam int S1_IDLE = 4;
	localparam int S1_OVERRUN = 3;
	localparam int S1_NOISE = 2;
	localparam int S1_FRAMING = 1;
	localparam int S1_PARITY = 0;
	localparam logic [7:0] S1_RESET = 8'hC0;
	// ------------------------------------------------------------
	// Status two fields
	// ------------------------------------------------------------
	localparam int S2_BREAK = 1;
	localparam int S2_IN_PROGRESS = 0;
	// Character bit positions
	localparam int CHAR_BIT_SEVEN = 7;
	localparam int CHAR_BIT_EIGHT = 8;
endpackage

// file: verification/sse_status_props.sv
// Checker: bus timing, interrupt gating and control outputs of the status block
module sse_status_props (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Shifter side and requests
	input wire logic [7:0] tx_data,
	input wire logic tx_ninth_bit,
	input wire logic tx_data_write,
	input wire logic rx_noise_event,
	input wire logic tx_irq,
	input wire logic rx_irq,
	input wire logic err_irq,
	input wire logic tx_dma_req,
	input wire logic rx_enable
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Completed good write, and an address outside the map
	wire logic wr_ok = psel && penable && pready && pwrite && !pslverr;
	wire logic unmapped = paddr > 8'h10 || paddr[1:0] != 2'h0;
	logic [7:0] c2_sh; // Shadow of control two
	logic [7:0] c3_sh; // Shadow of control three
	// ----------------------------------------
	// Control shadows, updated at write completion
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			c2_sh <= 8'h00;
			c3_sh <= 8'h00;
		end else if (wr_ok && paddr == sse_pkg::OFS_CONTROL_TWO) begin
			c2_sh <= pwdata[7:0];
		end else if (wr_ok && paddr == sse_pkg::OFS_CONTROL_THREE) begin
			c3_sh <= pwdata[7:0];
		end
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	a_one_wait: assert property (psel && penable && !pready |=> pready)
		else $error("pready not one cycle after access start");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_unmapped_err: assert property (pready |-> pslverr == unmapped)
		else $error("pslverr does not match address map");
	a_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	a_data_strobe: assert property (wr_ok && paddr == sse_pkg::OFS_DATA_BUFFER
		|=> tx_data_write && tx_data == $past(pwdata[7:0]) ##1 !tx_data_write)
		else $error("data write strobe or byte wrong");
	a_ninth_follow: assert property (tx_ninth_bit == c3_sh[6])
		else $error("transmit ninth bit differs from control");
	a_rx_en_follow: assert property (rx_enable == c2_sh[2])
		else $error("receiver enable differs from control");
	a_err_gate: assert property (err_irq |-> $past(c3_sh[3:0]) != 4'h0)
		else $error("error request with all enables clear");
	a_noise_irq: assert property (rx_noise_event && c3_sh[2] |-> ##2 err_irq)
		else $error("enabled noise did not raise error request");
	a_tx_gate: assert property (tx_irq |-> $past(c2_sh[7] && !c3_sh[4] || c2_sh[6]))
		else $error("transmit request without enable");
	a_dma_divert: assert property (tx_dma_req |-> $past(c3_sh[4]))
		else $error("dma request without steering");
	a_rx_gate: assert property (rx_irq |-> $past(c2_sh[5] || c2_sh[4]))
		else $error("receive request without enable");
endmodule

bind sse_status_flags sse_status_props u_props (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.tx_data(tx_data), .tx_ninth_bit(tx_ninth_bit), .tx_data_write(tx_data_write),
	.rx_noise_event(rx_noise_event), .tx_irq(tx_irq), .rx_irq(rx_irq), .err_irq(err_irq),
	.tx_dma_req(tx_dma_req), .rx_enable(rx_enable)
);

// file: verification/sse_shifter_model.sv
// Shifter-side model: receive events on command, transmit take-up after a data write
module sse_shifter_model (
	// Clock
	input wire logic pclk,
	// From the status block
	input wire logic tx_data_write,
	input wire logic [7:0] tx_data,
	// To the status block
	output logic tx_load_pulse,
	output logic tx_busy,
	output logic tx_queue_pulse,
	output logic nine_bit_mode,
	output logic rx_char_done,
	output logic [8:0] rx_char,
	output logic rx_noise_event,
	output logic rx_parity_event,
	output logic rx_stop_zero_event,
	output logic rx_break_event,
	output logic rx_line_ones_event,
	output logic rx_idle_event,
	output logic rx_start_sample_zero,
	output logic rx_false_start
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] tx_seen; // Last byte taken over
	logic [4:0] tx_cnt = 5'h00; // Cycles since take-over, zero when idle
	// Quiet line at start
	initial begin
		{nine_bit_mode, rx_char_done} = '0;
		{rx_noise_event, rx_parity_event, rx_stop_zero_event, rx_break_event} = '0;
		{rx_line_ones_event, rx_idle_event, rx_start_sample_zero, rx_false_start} = '0;
		rx_char = 9'h000;
	end
	// Take the byte, then after a gap load it and stay busy sending it
	always @(posedge pclk) begin
		if (tx_cnt != 5'h00) begin
			tx_cnt <= (tx_cnt == 5'h0F) ? 5'h00 : tx_cnt + 5'h01;
		end else if (tx_data_write === 1'b1) begin
			tx_seen <= tx_data;
			tx_cnt <= 5'h01;
		end
	end
	assign tx_queue_pulse = (tx_cnt == 5'h05);
	assign tx_load_pulse = (tx_cnt == 5'h05);
	assign tx_busy = (tx_cnt >= 5'h05);
	// One received character or break; data lines flip afterwards
	task automatic rx_ev(input logic [8:0] d, input logic [2:0] err, input logic brk);
		@(posedge pclk);
		rx_char <= d;
		rx_char_done <= !brk;
		rx_break_event <= brk;
		rx_noise_event <= err[2];
		rx_stop_zero_event <= err[1];
		rx_parity_event <= err[0];
		@(posedge pclk);
		rx_char <= ~d;
		{rx_char_done, rx_break_event} <= 2'h0;
		{rx_noise_event, rx_stop_zero_event, rx_parity_event} <= 3'h0;
	endtask
	// Line event: 0 ones, 1 idle, 2 start zero, 3 false start
	task automatic line_ev(input int k);
		@(posedge pclk);
		rx_line_ones_event <= (k == 0);
		rx_idle_event <= (k == 1);
		rx_start_sample_zero <= (k == 2);
		rx_false_start <= (k == 3);
		@(posedge pclk);
		{rx_line_ones_event, rx_idle_event, rx_start_sample_zero, rx_false_start} <= 4'h0;
	endtask
endmodule

// file: verification/tb_top.sv
// Testbench: register access, clearing sequences, error gating and break handling
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] C2 = sse_pkg::OFS_CONTROL_TWO;
	localparam logic [7:0] C3 = sse_pkg::OFS_CONTROL_THREE;
	localparam logic [7:0] S1 = sse_pkg::OFS_STATUS_ONE;
	localparam logic [7:0] S2 = sse_pkg::OFS_STATUS_TWO;
	localparam logic [7:0] DB = sse_pkg::OFS_DATA_BUFFER;
	// Bus and reset
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr, tx_data;
	logic [31:0] pwdata, prdata, rv;
	// Shifter side and requests
	logic tx_load_pulse, tx_busy, tx_queue_pulse, tx_ninth_bit, tx_data_write, nine_bit_mode;
	logic rx_char_done, rx_noise_event, rx_parity_event, rx_stop_zero_event, rx_break_event;
	logic rx_line_ones_event, rx_idle_event, rx_start_sample_zero, rx_false_start;
	logic [8:0] rx_char;
	logic tx_irq, rx_irq, err_irq, tx_dma_req, rx_enable, ev;
	logic [2:0] e; // Error kind under test
	int n_mismatch = 0;
	int cmp_count = 0;
	int cyc = 0;
	sse_status_flags DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.tx_load_pulse(tx_load_pulse), .tx_busy(tx_busy), .tx_queue_pulse(tx_queue_pulse),
		.tx_data(tx_data), .tx_ninth_bit(tx_ninth_bit), .tx_data_write(tx_data_write),
		.nine_bit_mode(nine_bit_mode), .rx_char_done(rx_char_done), .rx_char(rx_char),
		.rx_noise_event(rx_noise_event), .rx_parity_event(rx_parity_event),
		.rx_stop_zero_event(rx_stop_zero_event), .rx_break_event(rx_break_event),
		.rx_line_ones_event(rx_line_ones_event), .rx_idle_event(rx_idle_event),
		.rx_start_sample_zero(rx_start_sample_zero), .rx_false_start(rx_false_start),
		.tx_irq(tx_irq), .rx_irq(rx_irq), .err_irq(err_irq), .tx_dma_req(tx_dma_req),
		.rx_enable(rx_enable)
	);
	sse_shifter_model shf (
		.pclk(pclk), .tx_data_write(tx_data_write), .tx_data(tx_data),
		.tx_load_pulse(tx_load_pulse), .tx_busy(tx_busy), .tx_queue_pulse(tx_queue_pulse),
		.nine_bit_mode(nine_bit_mode), .rx_char_done(rx_char_done), .rx_char(rx_char),
		.rx_noise_event(rx_noise_event), .rx_parity_event(rx_parity_event),
		.rx_stop_zero_event(rx_stop_zero_event), .rx_break_event(rx_break_event),
		.rx_line_ones_event(rx_line_ones_event), .rx_idle_event(rx_idle_event),
		.rx_start_sample_zero(rx_start_sample_zero), .rx_false_start(rx_false_start)
	);
	// 25 MHz clock
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	// Hang guard
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			wrap_up();
		end
	end
	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One APB transfer, held until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rv = prdata;
		ev = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] x);
		apb(1'b0, a, 32'h0);
		chk(rv, {24'h0, x});
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'hA5A5A5, d});
	endtask
	task automatic bit_is(input logic b, input logic x);
		chk({31'h0, b}, {31'h0, x});
	endtask
	task automatic done(input string s);
		$display("Test done: %s", s);
	endtask
	// Verdict
	task automatic wrap_up();
		$display("Compares %0d, mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		{psel, penable, pwrite, presetn} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd(S1, 8'hC0);
		rd(S2, 8'h00);
		wr(C2, 8'hFF);
		rd(C2, 8'hF4);
		wr(C2, 8'h80);
		wr(C3, 8'hFF);
		rd(C3, 8'h7F);
		bit_is(tx_dma_req, 1'b1);
		bit_is(tx_irq, 1'b0);
		wr(C3, 8'h00);
		repeat (2) @(posedge pclk);
		bit_is(tx_irq, 1'b1);
		wr(C2, 8'h00);
		apb(1'b0, 8'h14, 32'h0);
		bit_is(ev, 1'b1);
		done("reset and map");
		wr(DB, 8'h5A);
		repeat (20) @(posedge pclk);
		rd(S1, 8'hC0);
		chk({24'h0, shf.tx_seen}, 32'h5A);
		wr(DB, 8'hA5);
		rd(S1, 8'h00);
		repeat (2) @(posedge pclk);
		rd(S1, 8'h80);
		repeat (12) @(posedge pclk);
		rd(S1, 8'hC0);
		done("transmit");
		shf.rx_ev(9'h03C, 3'h0, 1'b0);
		rd(S1, 8'hE0);
		rd(DB, 8'h3C);
		rd(S1, 8'hC0);
		shf.rx_ev(9'h011, 3'h0, 1'b0);
		shf.rx_ev(9'h022, 3'h0, 1'b0);
		rd(S1, 8'hE8);
		rd(DB, 8'h11);
		rd(S1, 8'hC0);
		shf.rx_ev(9'h033, 3'h0, 1'b0);
		rd(S1, 8'hE0);
		shf.rx_ev(9'h044, 3'h0, 1'b0);
		rd(DB, 8'h33);
		rd(S1, 8'hC8);
		rd(DB, 8'h33);
		rd(S1, 8'hC0);
		done("receive and overrun");
		for (int k = 0; k < 6; k++) begin
			e = 3'(1 << (k % 3));
			wr(C3, (k < 3) ? {5'h00, e} : {5'h00, ~e});
			shf.rx_ev(9'h0AA, e, 1'b0);
			rd(S1, {5'h1C, e});
			bit_is(err_irq, k < 3);
			rd(DB, 8'hAA);
			repeat (2) @(posedge pclk);
			rd(S1, 8'hC0);
			bit_is(err_irq, 1'b0);
		end
		wr(C3, 8'h00);
		done("error flags");
		wr(C2, 8'h14);
		shf.line_ev(1);
		rd(S1, 8'hC0);
		shf.rx_ev(9'h055, 3'h0, 1'b0);
		rd(S1, 8'hE0);
		bit_is(rx_irq, 1'b0);
		rd(DB, 8'h55);
		shf.line_ev(1);
		rd(S1, 8'hD0);
		bit_is(rx_irq, 1'b1);
		rd(DB, 8'h55);
		rd(S1, 8'hC0);
		shf.line_ev(1);
		rd(S1, 8'hC0);
		shf.line_ev(2);
		rd(S2, 8'h01);
		shf.line_ev(3);
		rd(S2, 8'h00);
		shf.line_ev(2);
		shf.line_ev(1);
		rd(S2, 8'h00);
		done("idle and progress");
		@(posedge pclk);
		shf.nine_bit_mode <= 1'b1;
		shf.rx_ev(9'h1FF, 3'h0, 1'b0);
		rd(C3, 8'h80);
		rd(S1, 8'hE0);
		rd(DB, 8'hFF);
		shf.rx_ev(9'h000, 3'h0, 1'b1);
		rd(S1, 8'hE2);
		rd(S2, 8'h02);
		rd(C3, 8'h00);
		rd(DB, 8'h00);
		rd(S2, 8'h00);
		rd(S1, 8'hC0);
		shf.rx_ev(9'h000, 3'h0, 1'b1);
		rd(S2, 8'h00);
		apb(1'b0, S1, 32'h0);
		apb(1'b0, DB, 32'h0);
		shf.line_ev(0);
		shf.rx_ev(9'h000, 3'h0, 1'b1);
		rd(S2, 8'h02);
		done("break");
		wrap_up();
	end
endmodule
